// >>> hdl/countdown_timer.sv
// Purpose: 16-bit protocol aware countdown timer behind an APB slave
// Assumes: ref_strobe marks each 13.56 MHz reference period in pclk
// Notes:   one access cycle per transfer, no wait states
//
// Notes on behaviour
// - auto start at every transmission end
// - auto, single frame: stop at fifth bit
// - auto, multi frame: fifth bit ignored, only halt or expiry stops
// - auto off: protocol events ignored
// - gate field: none, first pin, second pin
// - active flag independent of gate level
// - reload on zero restarts from reload
// - no restart: stop at zero, raise request
// - prescaler split high nibble, low byte
// - odd divide: 2p+1 reference periods
// - even divide: 2p+2 reference periods
// - reload value loaded at start and on restart at zero
// - prescaler low byte at 2Bh, reset 00h
`timescale 1ns/1ps
module countdown_timer
    import countdown_timer_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  ref_strobe,
    input  wire logic                  tx_end,
    input  wire logic                  rx_bit_strobe,
    input  wire logic                  first_gate_input_pin,
    input  wire logic                  second_gate_input_pin,
    output logic                       timer_active_flag,
    output logic                       irq
);
    // the decode needs index bits 9:2, so narrower buses are refused at elaboration
    if (ADDR_WIDTH < 10 || ADDR_WIDTH > 32) begin
        $error("address width out of range");
    end

    typedef struct packed {
        logic [7:0]             mode;
        logic [7:0]             presc_low;
        logic [COUNT_WIDTH-1:0] reload;
        logic [COUNT_WIDTH-1:0] count;
        logic [1:0]             config_bits;
        logic                   active;
        logic                   expired;
        logic                   mask;
        logic                   irq;
        logic                   ready;
        logic                   slverr;
        logic [31:0]            rdata;
    } timer_state_t;

    timer_state_t st_reg;
    timer_state_t st_next;

    logic                   setup;
    logic                   wr_edge;
    logic [7:0]             index;
    logic                   word_ok;
    logic                   mapped;
    logic [7:0]             rd_byte;
    logic                   auto_start;
    logic [1:0]             gate_sel;
    logic                   gate_open;
    logic                   start_event;
    logic                   stop_event;
    logic                   halt_now;
    logic                   sw_start;
    logic                   tick;
    logic                   fifth_bit;
    logic [PRESC_WIDTH-1:0] presc_value;

    // bus decode; word aligned addresses only, upper bits must be zero
    assign setup   = psel && !penable;
    assign wr_edge = psel && penable && st_reg.ready && pwrite && pstrb[0];
    assign index   = paddr[9:2];
    assign word_ok = (paddr[1:0] == 2'h0) && ({paddr, 2'h0} >> 12) == '0;

    // configuration fields
    assign auto_start  = st_reg.mode[MODE_AUTO_BIT];
    assign gate_sel    = st_reg.mode[MODE_GATE_LSB +: 2];
    assign presc_value = {st_reg.mode[MODE_PRESC_LSB +: 4], st_reg.presc_low};

    // gate source select; code 11 is treated as ungated
    always_comb begin
        case (gate_sel)
            GATE_NONE:   gate_open = 1'b1;
            GATE_FIRST:  gate_open = first_gate_input_pin;
            GATE_SECOND: gate_open = second_gate_input_pin;
            default:     gate_open = 1'b1;
        endcase
    end

    // control strobes act at the access edge of a write; a refused address
    // aliases onto the control index, so it must not fire a strobe
    assign halt_now = wr_edge && word_ok && index == CONTROL_IDX && pwdata[CTRL_HALT_BIT];
    assign sw_start = wr_edge && word_ok && index == CONTROL_IDX && pwdata[CTRL_START_BIT];

    // protocol events only count while auto start is set
    assign start_event = sw_start || (auto_start && tx_end);
    assign stop_event  = halt_now
                      || (auto_start && !st_reg.config_bits[CFG_MULTI_BIT] && fifth_bit);

    // prescaler stalls with the gate closed so partial ticks are kept
    tick_prescaler #(
        .PW (PRESC_WIDTH)
    ) u_presc (
        .pclk        (pclk),
        .presetn     (presetn),
        .clear       (start_event),
        .run         (st_reg.active && gate_open),
        .ref_strobe  (ref_strobe),
        .divisor     (presc_value),
        .even_divide (st_reg.config_bits[CFG_EVEN_BIT]),
        .tick        (tick)
    );

    rx_bit_watch #(
        .BITS (STOP_BIT_COUNT)
    ) u_watch (
        .pclk          (pclk),
        .presetn       (presetn),
        .arm           (start_event),
        .rx_bit_strobe (rx_bit_strobe),
        .fifth_bit     (fifth_bit)
    );

    // read mux, unmapped words flag an error and read zero
    always_comb begin
        mapped  = 1'b1;
        rd_byte = 8'h00;
        case (index)
            TIMER_MODE_IDX:  rd_byte = st_reg.mode;
            PRESC_LOW_IDX:   rd_byte = st_reg.presc_low;
            RELOAD_HIGH_IDX: rd_byte = st_reg.reload[15:8];
            RELOAD_LOW_IDX:  rd_byte = st_reg.reload[7:0];
            COUNT_HIGH_IDX:  rd_byte = st_reg.count[15:8];
            COUNT_LOW_IDX:   rd_byte = st_reg.count[7:0];
            CONTROL_IDX:     rd_byte = 8'h00;
            CONFIG_IDX:      rd_byte = {6'h00, st_reg.config_bits};
            STATUS_IDX:      rd_byte = {7'h00, st_reg.active};
            IRQ_STATUS_IDX:  rd_byte = {7'h00, st_reg.expired};
            IRQ_MASK_IDX:    rd_byte = {7'h00, st_reg.mask};
            default:         mapped = 1'b0;
        endcase
        if (!word_ok) begin
            mapped  = 1'b0;
            rd_byte = 8'h00;
        end
    end

    // next state of the whole block
    always_comb begin
        st_next = st_reg;

        // answer prepared in setup, shown during the single access cycle
        st_next.ready  = setup;
        st_next.slverr = setup && !mapped;
        st_next.rdata  = (setup && !pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;

        // register writes; count and status are read only
        if (wr_edge && word_ok) begin
            case (index)
                TIMER_MODE_IDX:  st_next.mode = pwdata[7:0];
                PRESC_LOW_IDX:   st_next.presc_low = pwdata[7:0];
                RELOAD_HIGH_IDX: st_next.reload[15:8] = pwdata[7:0];
                RELOAD_LOW_IDX:  st_next.reload[7:0] = pwdata[7:0];
                CONFIG_IDX:      st_next.config_bits = pwdata[1:0];
                IRQ_MASK_IDX:    st_next.mask = pwdata[IRQ_EXPIRED_BIT];
                IRQ_STATUS_IDX:  begin
                    if (pwdata[IRQ_EXPIRED_BIT]) begin
                        st_next.expired = 1'b0;
                    end
                end
                default:         st_next.expired = st_reg.expired;
            endcase
        end

        // counting; the reload registers reach the counter at start and on restart at zero
        if (stop_event) begin
            st_next.active = 1'b0;
        end else if (start_event) begin
            st_next.active = 1'b1;
            st_next.count  = st_reg.reload;
        end else if (tick) begin
            if (st_reg.count == '0) begin
                if (st_reg.mode[MODE_RESTART_BIT]) begin
                    st_next.count = st_reg.reload;
                end else begin
                    st_next.active  = 1'b0;
                    st_next.expired = 1'b1;
                end
            end else begin
                st_next.count = st_reg.count - 1'b1;
            end
        end

        // level interrupt from the masked sticky flag
        st_next.irq = st_next.expired && st_next.mask;
    end

    // every output is taken straight from a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg             <= '0;
            st_reg.mode        <= TIMER_MODE_RESET;
            st_reg.presc_low   <= PRESC_LOW_RESET;
            st_reg.reload      <= RELOAD_RESET;
            st_reg.count       <= COUNT_RESET;
            st_reg.config_bits <= CONFIG_RESET;
            st_reg.mask        <= IRQ_MASK_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata            = st_reg.rdata;
    assign pready            = st_reg.ready;
    assign pslverr           = st_reg.slverr;
    assign timer_active_flag = st_reg.active;
    assign irq               = st_reg.irq;
endmodule

// >>> hdl/rx_bit_watch.sv
// Purpose: flag the fifth received bit after a timer start
// Assumes: rx_bit_strobe pulses once per received bit, start bit first
// Notes:   disarms after firing so later bits are ignored
`timescale 1ns/1ps
module rx_bit_watch
    import countdown_timer_pkg::*;
#(
    parameter int BITS = STOP_BIT_COUNT
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic arm,
    input  wire logic rx_bit_strobe,
    output logic      fifth_bit
);
    // the bit counter is four bits wide
    if (BITS < 1 || BITS > 15) begin
        $error("bit count out of range");
    end

    typedef struct packed {
        logic       armed;
        logic [3:0] seen;
    } watch_state_t;

    watch_state_t st_reg;
    watch_state_t st_next;

    // count bits only while armed by a start event
    always_comb begin
        fifth_bit = st_reg.armed && rx_bit_strobe && (st_reg.seen == 4'(BITS - 1));
        st_next   = st_reg;
        if (arm) begin
            st_next.armed = 1'b1;
            st_next.seen  = 4'h0;
        end else if (fifth_bit) begin
            st_next.armed = 1'b0;
        end else if (st_reg.armed && rx_bit_strobe) begin
            st_next.seen = st_reg.seen + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// >>> hdl/tick_prescaler.sv
// Purpose: divide the reference strobe into timer ticks
// Assumes: ref_strobe is one pclk cycle per reference period
// Notes:   period is 2p+1 or 2p+2 reference strobes
`timescale 1ns/1ps
module tick_prescaler
    import countdown_timer_pkg::*;
#(
    parameter int PW = PRESC_WIDTH
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          clear,
    input  wire logic          run,
    input  wire logic          ref_strobe,
    input  wire logic [PW-1:0] divisor,
    input  wire logic          even_divide,
    output logic               tick
);
    // refuse widths the terminal count cannot hold
    if (PW < 1 || PW > 16) begin
        $error("prescaler width out of range");
    end

    typedef struct packed {
        logic [PW+1:0] div;
    } presc_state_t;

    presc_state_t st_reg;
    presc_state_t st_next;
    logic [PW+1:0] last;

    // odd or even division selects the terminal count
    always_comb begin
        last    = {1'b0, divisor, 1'b0} + {{(PW+1){1'b0}}, even_divide};
        tick    = run && ref_strobe && (st_reg.div == last);
        st_next = st_reg;
        if (clear) begin
            st_next.div = '0;
        end else if (run && ref_strobe) begin
            st_next.div = tick ? '0 : st_reg.div + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// >>> shared/countdown_timer_pkg.sv
// Purpose: shared constants for the protocol aware countdown timer
// Assumes: APB register window, one 32-bit word per byte register
// Notes:   register indices are scaled by four to form byte addresses
package countdown_timer_pkg;
    // register indices, byte address is index times four
    localparam logic [7:0] TIMER_MODE_IDX   = 8'h2A;
    localparam logic [7:0] PRESC_LOW_IDX    = 8'h2B;
    localparam logic [7:0] RELOAD_HIGH_IDX  = 8'h2C;
    localparam logic [7:0] RELOAD_LOW_IDX   = 8'h2D;
    localparam logic [7:0] COUNT_HIGH_IDX   = 8'h2E;
    localparam logic [7:0] COUNT_LOW_IDX    = 8'h2F;
    localparam logic [7:0] CONTROL_IDX      = 8'h40;
    localparam logic [7:0] CONFIG_IDX       = 8'h41;
    localparam logic [7:0] STATUS_IDX       = 8'h42;
    localparam logic [7:0] IRQ_STATUS_IDX   = 8'h43;
    localparam logic [7:0] IRQ_MASK_IDX     = 8'h44;

    // timer mode fields
    localparam int MODE_AUTO_BIT    = 7;
    localparam int MODE_GATE_LSB    = 5;
    localparam int MODE_RESTART_BIT = 4;
    localparam int MODE_PRESC_LSB   = 0;

    // control fields, self clearing strobes
    localparam int CTRL_HALT_BIT  = 0;
    localparam int CTRL_START_BIT = 1;

    // config fields
    localparam int CFG_EVEN_BIT  = 0;
    localparam int CFG_MULTI_BIT = 1;

    // status and interrupt fields
    localparam int STATUS_ACTIVE_BIT = 0;
    localparam int IRQ_EXPIRED_BIT   = 0;

    // reset values
    localparam logic [7:0]  TIMER_MODE_RESET = 8'h00;
    localparam logic [7:0]  PRESC_LOW_RESET  = 8'h00;
    localparam logic [15:0] RELOAD_RESET     = 16'h0000;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;
    localparam logic [1:0]  CONFIG_RESET     = 2'h0;
    localparam logic        IRQ_MASK_RESET   = 1'b0;

    // gate source codes
    localparam logic [1:0] GATE_NONE   = 2'h0;
    localparam logic [1:0] GATE_FIRST  = 2'h1;
    localparam logic [1:0] GATE_SECOND = 2'h2;

    // widths and protocol counts
    localparam int PRESC_WIDTH      = 12;
    localparam int COUNT_WIDTH      = 16;
    localparam int STOP_BIT_COUNT   = 5;
    localparam real REF_CLOCK_MHZ   = 13.56;
endpackage

// >>> tb/countdown_timer_monitor.sv
// Purpose: port checks for the countdown timer
// Assumes: mode, config and mask are shadowed from bus writes
// Notes:   stop windows leave out bus traffic and ticks
`timescale 1ns/1ps
module countdown_timer_monitor
    import countdown_timer_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  ref_strobe,
    input wire logic                  tx_end,
    input wire logic                  rx_bit_strobe,
    input wire logic                  first_gate_input_pin,
    input wire logic                  second_gate_input_pin,
    input wire logic                  timer_active_flag,
    input wire logic                  irq
);
    logic       wr;
    logic       ctrl_wr;
    logic [7:0] mode_q;
    logic       multi_q;
    logic       mask_q;
    // address passed in so assertions see its sampled value
    function automatic logic hit(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] idx);
        return a == ADDR_WIDTH'({idx, 2'b00});
    endfunction
    // a completed write that the block accepts
    assign wr      = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
    assign ctrl_wr = wr && hit(paddr, CONTROL_IDX);
    // shadows of the settings, so the rules can be judged from outside
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q  <= 8'h00;
            multi_q <= 1'b0;
            mask_q  <= 1'b0;
        end else if (wr) begin
            if (hit(paddr, TIMER_MODE_IDX)) mode_q <= pwdata[7:0];
            if (hit(paddr, CONFIG_IDX)) multi_q <= pwdata[CFG_MULTI_BIT];
            if (hit(paddr, IRQ_MASK_IDX)) mask_q <= pwdata[0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
    a_misaligned_error: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr && pready)
        else $error("no error");
    a_halt_stops: assert property (ctrl_wr && pwdata[CTRL_HALT_BIT] |=> !timer_active_flag)
        else $error("halt ignored");
    a_start_runs: assert property (ctrl_wr && pwdata[1:0] == 2'b10 |=> timer_active_flag)
        else $error("start ignored");
    a_auto_start: assert property (mode_q[7] && tx_end && !rx_bit_strobe && !psel |=> timer_active_flag)
        else $error("no auto start");
    a_auto_off: assert property (!mode_q[7] && tx_end && !timer_active_flag && !psel |=> !timer_active_flag)
        else $error("started while auto off");
    a_multi_keeps: assert property (mode_q[7] && multi_q && timer_active_flag && !ref_strobe && !psel
        |=> timer_active_flag) else $error("stopped in multi frame");
    a_gate_holds_run: assert property (timer_active_flag && !ref_strobe && !rx_bit_strobe && !psel
        |=> timer_active_flag) else $error("stopped without cause");
    a_irq_masked: assert property (irq |-> mask_q || $past(mask_q)) else $error("irq while masked");
    a_irq_cause: assert property ($rose(irq) |-> $fell(timer_active_flag) || $past(wr) || $past(wr, 2))
        else $error("irq without expiry");
    c_start: cover property (ctrl_wr);
    c_irq: cover property ($rose(irq));
    c_rx_run: cover property (mode_q[7] && rx_bit_strobe && timer_active_flag);
endmodule

bind countdown_timer countdown_timer_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) countdown_timer_monitor_inst (.*);

// >>> tb/countdown_timer_tb.sv
// Purpose: register level test of the countdown timer
// Assumes: ticks are counted by hand from single ref strobes
// Notes:   prescaler kept tiny except in the high nibble check, so the run stays short
`timescale 1ns/1ps
module countdown_timer_tb
    import countdown_timer_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        timer_active_flag, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [2:0]  ev;
    logic [1:0]  gate;
    logic [7:0]  q;
    int          n_errors = 0;
    int          checks_done = 0;
    // ev carries rx, tx end and ref strobes, gate the two pin levels
    countdown_timer countdown_timer_inst (.*, .ref_strobe(ev[0]), .tx_end(ev[1]), .rx_bit_strobe(ev[2]),
        .first_gate_input_pin(gate[0]), .second_gate_input_pin(gate[1]));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // one transfer; request held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            n_errors++;
            complete_run();
        end
        q = prdata[7:0];
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, {2'b00, idx, 2'b00}, d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string nm);
        xfer(1'b0, {2'b00, idx, 2'b00}, 8'h00);
        chk(nm, {8'h00, q}, {8'h00, exp});
    endtask
    task automatic rdc(input logic [15:0] exp);
        rd(COUNT_HIGH_IDX, exp[15:8], "count high");
        rd(COUNT_LOW_IDX, exp[7:0], "count low");
    endtask
    // flag is read one edge later so the launching edge has landed
    task automatic act(input logic exp);
        @(posedge pclk);
        chk("active", {15'h0000, timer_active_flag}, {15'h0000, exp});
    endtask
    task automatic pulse(input logic [2:0] m, input int n);
        repeat (n) begin
            @(posedge pclk);
            ev <= m;
            @(posedge pclk);
            ev <= 3'b000;
        end
    endtask
    task automatic load(input logic [7:0] mode, input logic [15:0] rl);
        wr(TIMER_MODE_IDX, mode);
        wr(RELOAD_HIGH_IDX, rl[15:8]);
        wr(RELOAD_LOW_IDX, rl[7:0]);
        wr(CONTROL_IDX, 8'h02);
    endtask
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, ev} = '0;
        {paddr, pwdata} = '0;
        pstrb = 4'hF;
        gate  = 2'b11;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(TIMER_MODE_IDX, 8'h00, "mode reset");
        rd(PRESC_LOW_IDX, 8'h00, "presc low reset");
        rdc(16'h0000);
        rd(8'h30, 8'h00, "unmapped");
        chk("unmapped err", {15'h0000, e}, 16'h0001);
        xfer(1'b0, 12'h0A9, 8'h00);
        chk("misaligned err", {15'h0000, e}, 16'h0001);
        // low byte lane off: the write must not land
        pstrb <= 4'hE;
        wr(PRESC_LOW_IDX, 8'h55);
        pstrb <= 4'hF;
        rd(PRESC_LOW_IDX, 8'h00, "lane off");
        wr(TIMER_MODE_IDX, 8'h0A);
        wr(PRESC_LOW_IDX, 8'hC3);
        rd(TIMER_MODE_IDX, 8'h0A, "presc high");
        rd(PRESC_LOW_IDX, 8'hC3, "presc low");
        // p=1: three strobes a tick odd, four even
        wr(PRESC_LOW_IDX, 8'h01);
        load(8'h00, 16'h0105);
        pulse(3'b001, 6);
        rdc(16'h0103);
        wr(CONFIG_IDX, 8'h01);
        wr(CONTROL_IDX, 8'h02);
        pulse(3'b001, 7);
        rdc(16'h0104);
        wr(RELOAD_HIGH_IDX, 8'h02);
        rdc(16'h0104);
        wr(CONTROL_IDX, 8'h02);
        rdc(16'h0205);
        // gating by each pin, then ungated with the second pin closed
        wr(CONFIG_IDX, 8'h00);
        wr(PRESC_LOW_IDX, 8'h00);
        gate <= 2'b10;
        load(8'h20, 16'h0005);
        pulse(3'b001, 2);
        rdc(16'h0005);
        act(1'b1);
        gate <= 2'b01;
        pulse(3'b001, 2);
        rdc(16'h0003);
        wr(TIMER_MODE_IDX, 8'h40);
        pulse(3'b001, 2);
        rdc(16'h0003);
        wr(TIMER_MODE_IDX, 8'h00);
        pulse(3'b001, 1);
        rdc(16'h0002);
        load(8'h10, 16'h0001);
        pulse(3'b001, 2);
        rdc(16'h0001);
        rd(IRQ_STATUS_IDX, 8'h00, "no request");
        // expiry, masked then unmasked request, write one to clear
        load(8'h00, 16'h0001);
        pulse(3'b001, 2);
        rd(STATUS_IDX, 8'h00, "stopped");
        rd(IRQ_STATUS_IDX, 8'h01, "expired");
        chk("irq masked", {15'h0000, irq}, 16'h0000);
        wr(IRQ_MASK_IDX, 8'h01);
        repeat (2) @(posedge pclk);
        chk("irq", {15'h0000, irq}, 16'h0001);
        wr(IRQ_STATUS_IDX, 8'h01);
        repeat (2) @(posedge pclk);
        chk("irq clear", {15'h0000, irq}, 16'h0000);
        // protocol start and the fifth bit stop
        wr(TIMER_MODE_IDX, 8'h80);
        pulse(3'b010, 1);
        act(1'b1);
        pulse(3'b100, 4);
        act(1'b1);
        pulse(3'b100, 1);
        act(1'b0);
        wr(CONFIG_IDX, 8'h02);
        pulse(3'b010, 1);
        pulse(3'b100, 6);
        act(1'b1);
        wr(CONTROL_IDX, 8'h01);
        act(1'b0);
        // a refused start write aliasing onto control must not start the timer
        xfer(1'b1, 12'h101, 8'h02);
        chk("misaligned start err", {15'h0000, e}, 16'h0001);
        act(1'b0);
        wr(CONFIG_IDX, 8'h00);
        wr(TIMER_MODE_IDX, 8'h00);
        pulse(3'b010, 1);
        act(1'b0);
        wr(CONTROL_IDX, 8'h02);
        pulse(3'b100, 6);
        act(1'b1);
        // gate code 11 runs ungated even with both pins closed
        gate <= 2'b00;
        load(8'h60, 16'h0005);
        pulse(3'b001, 1);
        rdc(16'h0004);
        // high nibble set: p = 100h, one tick per 513 strobes
        load(8'h01, 16'h0010);
        pulse(3'b001, 512);
        rdc(16'h0010);
        pulse(3'b001, 1);
        rdc(16'h000F);
        complete_run();
    end
endmodule
